/* File: hdl/clock_phase_regs.svh */
// Constants for the clock phase interval counter.
`ifndef CLOCK_PHASE_REGS_SVH
`define CLOCK_PHASE_REGS_SVH
`define MEASURE_FUNCTION_CODE 5'h19
`define CHANNEL_ENABLE_FUNCTION_CODE 5'h1A
`define OVERFLOW_CLEAR_FUNCTION_CODE 5'h09
`define BEAT_REGISTER_CLEAR_FUNCTION_CODE 5'h0C
`define DISTRIBUTION_STATION 5'h02
`define MEASURE_SUBADDRESS 4'h0
`define COUNT_WIDTH 24
`define ARM_PULSE_CYCLES 4'h4
`endif

/* File: hdl/clock_phase_pkg.sv */
// Types for the clock phase interval counter.
package clock_phase_pkg;
  typedef struct packed {
    logic [4:0] function_code;
    logic [3:0] subaddress;
    logic [4:0] station;
    logic execute;
    logic to_controller;
  } command_type;
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_arm = 4'h2,
    st_wait_start = 4'h4,
    st_run = 4'h8
  } seq_state_type;
endpackage

/* File: hdl/clock_phase_interval_counter.sv */
// Measurement sequencer, per-channel phase counters and byte readout.
`timescale 1ns/10ps
`include "clock_phase_regs.svh"
module clock_phase_interval_counter #(
  parameter int channels = 4,
  parameter logic [4:0] module_station = 5'h03
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic command_valid,
  input wire clock_phase_pkg::command_type command,
  input wire logic beat_ref,
  input wire logic [channels-1:0] chan_ref,
  input wire logic [$clog2(channels)-1:0] read_channel,
  input wire logic read_beat,
  input wire logic [1:0] read_byte_index,
  output logic [7:0] read_data,
  output logic arm_pulse,
  output logic busy,
  output logic [channels-1:0] chan_done,
  output logic beat_overflow
);
  if (channels < 2 || channels > 16) begin : g_bad_channels
    $error("channels out of range");
  end
  if (module_station == `DISTRIBUTION_STATION || module_station == 5'h00) begin : g_bad_station
    $error("module_station must be a free nonzero station");
  end
  if (`COUNT_WIDTH != 24) begin : g_bad_width
    $error("count width must be 24 bits");
  end
  if (`ARM_PULSE_CYCLES == 4'h0) begin : g_bad_arm
    $error("arm pulse length must be nonzero");
  end

  clock_phase_pkg::seq_state_type state;
  logic [3:0] arm_count;
  logic [1:0] beat_sync;
  logic beat_last;
  logic [channels-1:0] chan_sync1;
  logic [channels-1:0] chan_sync2;
  logic [channels-1:0] chan_last;
  logic [channels-1:0] chan_run;
  logic [channels-1:0] chan_enable;
  logic [`COUNT_WIDTH-1:0] fast_count [channels];
  logic [`COUNT_WIDTH-1:0] beat_count [channels];
  logic [`COUNT_WIDTH-1:0] beat_total;
  logic beat_rise;
  logic accepted;
  logic measure_cmd;
  logic local_even;
  logic enable_cmd;
  logic clear_ovf_cmd;
  logic clear_beat_cmd;
  logic run_start;

  function automatic logic [7:0] pick_byte(input logic [`COUNT_WIDTH-1:0] w,
                                           input logic [1:0] idx);
    case (idx)
      2'h0: pick_byte = w[23:16];
      2'h1: pick_byte = w[15:8];
      2'h2: pick_byte = w[7:0];
      default: pick_byte = 8'h00;
    endcase
  endfunction

  function automatic logic is_code(input clock_phase_pkg::command_type cmd, input logic [4:0] code);
    is_code = cmd.function_code == code;
  endfunction

  assign accepted = command_valid && command.execute && command.to_controller;
  assign measure_cmd = accepted && command.function_code == `MEASURE_FUNCTION_CODE
    && command.subaddress == `MEASURE_SUBADDRESS
    && command.station == `DISTRIBUTION_STATION;
  assign local_even = accepted && command.station == module_station && !command.subaddress[0];
  assign beat_rise = beat_sync[1] && !beat_last;
  assign enable_cmd = local_even && is_code(command, `CHANNEL_ENABLE_FUNCTION_CODE);
  assign clear_ovf_cmd = local_even && is_code(command, `OVERFLOW_CLEAR_FUNCTION_CODE);
  assign clear_beat_cmd = local_even && is_code(command, `BEAT_REGISTER_CLEAR_FUNCTION_CODE);
  assign run_start = state == clock_phase_pkg::st_wait_start && beat_rise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      beat_sync <= 2'h0;
      beat_last <= 1'b0;
    end else begin
      beat_sync <= {beat_sync[0], beat_ref};
      beat_last <= beat_sync[1];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_sync1 <= '0;
      chan_sync2 <= '0;
      chan_last <= '0;
    end else begin
      chan_sync1 <= chan_ref;
      chan_sync2 <= chan_sync1;
      chan_last <= chan_sync2;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= clock_phase_pkg::st_idle;
      arm_count <= 4'h0;
      arm_pulse <= 1'b0;
      busy <= 1'b0;
    end else begin
      case (state)
        clock_phase_pkg::st_idle: begin
          if (measure_cmd) begin
            state <= clock_phase_pkg::st_arm;
            arm_count <= `ARM_PULSE_CYCLES;
            arm_pulse <= 1'b1;
            busy <= 1'b1;
          end
        end
        clock_phase_pkg::st_arm: begin
          if (arm_count == 4'h1) begin
            arm_pulse <= 1'b0;
            state <= clock_phase_pkg::st_wait_start;
          end
          arm_count <= arm_count - 4'h1;
        end
        clock_phase_pkg::st_wait_start: begin
          if (beat_rise) begin
            state <= clock_phase_pkg::st_run;
          end
        end
        clock_phase_pkg::st_run: begin
          if ((chan_run & chan_enable) == '0) begin
            state <= clock_phase_pkg::st_idle;
            busy <= 1'b0;
          end
        end
        default: state <= clock_phase_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_enable <= '0;
    end else if (enable_cmd) begin
      chan_enable <= '1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      beat_overflow <= 1'b0;
    end else if (beat_rise && beat_total == '1) begin
      beat_overflow <= 1'b1;
    end else if (clear_ovf_cmd) begin
      beat_overflow <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      beat_total <= '0;
    end else if (clear_beat_cmd) begin
      beat_total <= '0;
    end else if (beat_rise) begin
      beat_total <= beat_total + 1'b1;
    end
  end

  for (genvar c = 0; c < channels; c++) begin : g_chan
    logic stop_edge;
    assign stop_edge = chan_run[c] && chan_sync2[c] && !chan_last[c];

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        chan_run[c] <= 1'b0;
      end else if (state == clock_phase_pkg::st_arm) begin
        chan_run[c] <= 1'b0;
      end else if (run_start && chan_enable[c]) begin
        chan_run[c] <= 1'b1;
      end else if (stop_edge) begin
        chan_run[c] <= 1'b0;
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        chan_done[c] <= 1'b0;
      end else if (state == clock_phase_pkg::st_arm) begin
        chan_done[c] <= 1'b0;
      end else if (stop_edge) begin
        chan_done[c] <= 1'b1;
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        fast_count[c] <= '0;
      end else if (state == clock_phase_pkg::st_arm) begin
        fast_count[c] <= '0;
      end else if (chan_run[c] && !stop_edge) begin
        fast_count[c] <= fast_count[c] + 1'b1;
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        beat_count[c] <= '0;
      end else if (run_start && chan_enable[c]) begin
        beat_count[c] <= beat_total;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      read_data <= 8'h00;
    end else if (read_beat) begin
      read_data <= pick_byte(beat_count[read_channel], read_byte_index);
    end else begin
      read_data <= pick_byte(fast_count[read_channel], read_byte_index);
    end
  end
endmodule // clock_phase_interval_counter

/* File: sim/clock_phase_interval_counter_properties.sv */
// Port properties of the clock phase interval counter.
`timescale 1ns/10ps
module clock_phase_interval_counter_properties #(parameter int channels = 4) (
  input wire logic clk, nrst, command_valid, beat_ref, read_beat, arm_pulse, busy,
  input wire clock_phase_pkg::command_type command,
  input wire logic [channels-1:0] chan_ref, chan_done,
  input wire logic [$clog2(channels)-1:0] read_channel,
  input wire logic [1:0] read_byte_index,
  input wire logic [7:0] read_data,
  input wire logic beat_overflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic go;
  logic meas;
  assign go = command_valid && command.execute && command.to_controller;
  assign meas = go && {command.function_code, command.subaddress, command.station} == 14'h3202;
  sequence arm_seq;
    arm_pulse [*4] ##1 !arm_pulse;
  endsequence
  chk_arm_start: assert property (meas && !busy |=> arm_seq) else $error("arm pulse");
  chk_refuse_cmd: assert property (command_valid && !go && !busy |=> !busy) else $error("refuse");
  chk_arm_clear: assert property (arm_pulse && $past(arm_pulse) |-> chan_done == '0)
    else $error("arm clear");
  chk_done_hold: assert property (!arm_pulse |-> (chan_done & $past(chan_done)) == $past(chan_done))
    else $error("done hold");
  chk_done_rise: assert property ($rose(chan_done[0]) |-> busy) else $error("done rise");
  chk_busy_end: assert property ($fell(busy) |-> $past(&chan_done)) else $error("busy end");
  chk_pad_byte: assert property (read_byte_index == 2'h3 |=> read_data == 8'h00)
    else $error("pad byte");
  chk_read_hold: assert property (!busy && !$past(busy) && !command_valid && !$past(command_valid)
    && $stable({read_channel, read_beat, read_byte_index}) |=> $stable(read_data))
    else $error("read hold");
endmodule // clock_phase_interval_counter_properties
bind clock_phase_interval_counter clock_phase_interval_counter_properties #(.channels(channels)) props (.*);

/* File: sim/crate_controller_model.sv */
// Crate controller model that issues coded commands.
`timescale 1ns/10ps
module crate_controller_model (
  input wire logic clk,
  output clock_phase_pkg::command_type command,
  output logic command_valid
);
  initial command_valid = 0;
  initial command = '0;
  task automatic send(input logic [4:0] fc, input logic [3:0] sa, input logic [4:0] st,
    input logic [1:0] ex);
    @(negedge clk);
    command_valid = 1;
    command = '{fc, sa, st, ex[1], ex[0]};
    @(negedge clk);
    command_valid = 0;
    command = ~command;
  endtask
endmodule // crate_controller_model

/* File: sim/clock_phase_interval_counter_tb.sv */
// Self-checking bench for the clock phase interval counter.
`timescale 1ns/10ps
module clock_phase_interval_counter_tb;
  logic clk = 0, nrst = 0, beat_ref = 0, read_beat = 0, command_valid, arm_pulse, busy, beat_overflow;
  clock_phase_pkg::command_type command;
  logic [3:0] chan_ref = 0, chan_done;
  logic [1:0] read_channel = 0, read_byte_index = 0;
  logic [7:0] read_data;
  logic [23:0] c[4], b, b0;
  int error_cnt = 0, n_tests = 0, d[4];
  initial forever #5 clk = ~clk;
  crate_controller_model model (.clk(clk), .command(command), .command_valid(command_valid));
  clock_phase_interval_counter #(.channels(4)) dut (.clk(clk), .nrst(nrst),
    .command_valid(command_valid), .command(command), .beat_ref(beat_ref), .chan_ref(chan_ref),
    .read_channel(read_channel), .read_beat(read_beat), .read_byte_index(read_byte_index),
    .read_data(read_data), .arm_pulse(arm_pulse), .busy(busy), .chan_done(chan_done),
    .beat_overflow(beat_overflow));
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input int ch, input logic bt, output logic [23:0] v);
    for (int i = 0; i < 3; i++) begin
      @(negedge clk) {read_channel, read_beat, read_byte_index} = {ch[1:0], bt, i[1:0]};
      @(negedge clk) v = {v[15:0], read_data};
    end
  endtask
  task automatic measure();
    chan_ref = 0;
    model.send(5'h19, 4'h0, 5'h02, 2'b11);
    repeat (6) @(negedge clk);
    beat_ref = 1;
    for (int k = 0; k < 4; k++) d[k] = 1 + $urandom % 40;
    for (int t = 1; t <= 40; t++) begin
      @(negedge clk);
      for (int k = 0; k < 4; k++) if (t == d[k]) chan_ref[k] = 1;
    end
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) begin
      error_cnt++;
      results();
    end
    beat_ref = 0;
    chan_ref = 0;
    repeat (5) @(negedge clk);
    chan_ref = 4'hF;
  endtask
  initial begin
    void'($urandom(51495));
    repeat (12) @(negedge clk);
    nrst = 1;
    check("idle outputs", {arm_pulse, busy, chan_done, beat_overflow}, 24'h0);
    for (int k = 0; k < 4; k++) begin
      model.send(5'h19, 4'h0, k == 3 ? 5'h03 : 5'h02, k[1:0]);
      @(negedge clk) check("refused busy", busy, 24'h0);
    end
    $display("refusal done");
    model.send(5'h1A, 4'h0, 5'h03, 2'b11);
    model.send(5'h09, 4'h0, 5'h03, 2'b11);
    model.send(5'h0C, 4'h0, 5'h03, 2'b11);
    @(negedge clk) check("overflow", beat_overflow, 24'h0);
    for (int m = 0; m < 3; m++) begin
      measure();
      for (int k = 0; k < 4; k++) rd(k, 0, c[k]);
      @(negedge clk) read_byte_index = 2'h3;
      @(negedge clk) check("pad byte", read_data, 24'h0);
      for (int k = 1; k < 4; k++) check("count diff", c[k] - c[0], 24'(d[k] - d[0]));
      rd(m, 1, b);
      if (m > 0) check("beat step", b - b0, 24'h1);
      b0 = b;
      $display("measure %0d done", m);
    end
    results();
  end
endmodule // clock_phase_interval_counter_tb
